/* shared/rkir_pkg.sv */
// Purpose: Constants and types for the kickstart, interrupt and RAM-clear block
// Assumes: Single clock domain, plain register port, 8-bit data
// Notes: Register offsets are byte indices on the plain port
// Behaviour
// - Without main supply, a kickstart falling edge starts system power-on.
// - With main supply, a kickstart falling edge sets an interrupt flag.
// - Interrupt request pin is active low open drain, only pulled low.
// - Interrupt request stays asserted while any enabled status flag is set.
// - Enabled RAM-clear input low fills all 242 user RAM bytes with ffh.
// - Enabled RAM-clear works with or without main supply.
package rkir_pkg;

  localparam int unsigned RKIR_AW = 4;
  localparam int unsigned RKIR_DW = 8;

  // Register offsets
  localparam logic [3:0] RKIR_OFF_CTRL = 4'h0;
  localparam logic [3:0] RKIR_OFF_STATUS = 4'h1;
  localparam logic [3:0] RKIR_OFF_MASK = 4'h2;
  localparam logic [3:0] RKIR_OFF_STATE = 4'h3;

  // Control fields
  localparam int unsigned RKIR_CTRL_ABE_BIT = 0;
  localparam int unsigned RKIR_CTRL_KSE_BIT = 1;
  localparam int unsigned RKIR_CTRL_RCE_BIT = 2;
  localparam int unsigned RKIR_CTRL_PWR_OFF_BIT = 3;

  // Status and mask fields
  localparam int unsigned RKIR_NUM_EV = 3;
  localparam int unsigned RKIR_EV_KS_INT = 0;
  localparam int unsigned RKIR_EV_KS_WAKE = 1;
  localparam int unsigned RKIR_EV_RC_DONE = 2;

  // State register fields
  localparam int unsigned RKIR_ST_BUSY_BIT = 0;
  localparam int unsigned RKIR_ST_PWR_BIT = 1;
  localparam int unsigned RKIR_ST_SUPPLY_BIT = 2;
  localparam int unsigned RKIR_ST_KS_BIT = 3;

  // Reset values
  localparam logic [2:0] RKIR_CTRL_RST = 3'h0;
  localparam logic [2:0] RKIR_EV_RST = 3'h0;
  localparam logic [7:0] RKIR_BYTE_RST = 8'h00;

  // User RAM fill
  localparam logic [7:0] RKIR_RAM_BYTES = 8'hf2;
  localparam logic [7:0] RKIR_RAM_LAST = 8'hf1;
  localparam logic [7:0] RKIR_RAM_FILL = 8'hff;

  typedef enum logic [0:0] {
    RKIR_IDLE = 1'b0,
    RKIR_FILL = 1'b1
  } rkir_fill_t;

  typedef struct packed {
    logic abe;
    logic kickstart_enable;
    logic rce;
    logic [2:0] status;
    logic [2:0] mask;
    logic ks_prev;
    logic rc_prev;
    logic pwr_on;
    rkir_fill_t fill;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic irq;
  } rkir_state_t;

endpackage

/* hw/rkir_top.sv */
// Purpose: Kickstart power-on, interrupt request and manual RAM-clear control
// Assumes: All inputs synchronous to mclk_i; RAM written through fill port
// Notes: Interrupt pin is modelled as output value plus output enable
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
module rkir_top
  import rkir_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pins and supply
  input wire logic main_supply_ok_i,
  input wire logic kickstart_in_n_i,
  input wire logic ram_clear_in_n_i,
  output logic irq_n_o,
  output logic irq_oe_o,
  output logic pwr_on_o,
  // User RAM fill port
  output logic ram_we_o,
  output logic [7:0] ram_addr_o,
  output logic [7:0] ram_data_o
);

  rkir_state_t s_q;
  rkir_state_t s_d;

  logic ks_fall;
  logic rc_fall;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic wr_ctrl;

  always_comb
  begin
    s_d = s_q;
    wr_ctrl = wr_i && (addr_i == RKIR_OFF_CTRL);
    ks_fall = s_q.ks_prev && !kickstart_in_n_i;
    rc_fall = s_q.rc_prev && !ram_clear_in_n_i;
    ev_set = RKIR_EV_RST;
    ev_clr = RKIR_EV_RST;
    s_d.ks_prev = kickstart_in_n_i;
    s_d.rc_prev = ram_clear_in_n_i;

    // Control and mask registers
    if (wr_ctrl)
    begin
      s_d.abe = wdata_i[RKIR_CTRL_ABE_BIT];
      s_d.kickstart_enable = wdata_i[RKIR_CTRL_KSE_BIT];
      s_d.rce = wdata_i[RKIR_CTRL_RCE_BIT];
      if (wdata_i[RKIR_CTRL_PWR_OFF_BIT])
      begin
        s_d.pwr_on = 1'b0;
      end
    end
    if (wr_i && (addr_i == RKIR_OFF_MASK))
    begin
      s_d.mask = wdata_i[2:0];
    end

    // Kickstart handling
    if (ks_fall && !main_supply_ok_i && s_q.abe && s_q.kickstart_enable)
    begin
      s_d.pwr_on = 1'b1;
      ev_set[RKIR_EV_KS_WAKE] = 1'b1;
    end
    if (ks_fall && main_supply_ok_i)
    begin
      ev_set[RKIR_EV_KS_INT] = 1'b1;
    end

    // RAM fill sequencer, independent of main supply
    unique case (s_q.fill)
      RKIR_IDLE:
      begin
        if (rc_fall && s_q.rce)
        begin
          s_d.fill = RKIR_FILL;
          s_d.addr = RKIR_BYTE_RST;
        end
      end
      RKIR_FILL:
      begin
        if (s_q.addr == RKIR_RAM_LAST)
        begin
          s_d.fill = RKIR_IDLE;
          ev_set[RKIR_EV_RC_DONE] = 1'b1;
        end
        else
        begin
          s_d.addr = s_q.addr + 8'h01;
        end
      end
    endcase

    // Sticky status, write one to clear, set wins
    if (wr_i && (addr_i == RKIR_OFF_STATUS))
    begin
      ev_clr = wdata_i[2:0];
    end
    s_d.status = (s_q.status & ~ev_clr) | ev_set;

    // Line held while any enabled flag stays set
    s_d.irq = |(s_d.status & s_d.mask);

    // Read data, one cycle after the strobe
    s_d.rdata = RKIR_BYTE_RST;
    if (rd_i)
    begin
      unique case (addr_i)
        RKIR_OFF_CTRL:
        begin
          s_d.rdata = {5'h00, s_q.rce, s_q.kickstart_enable, s_q.abe};
        end
        RKIR_OFF_STATUS:
        begin
          s_d.rdata = {5'h00, s_q.status};
        end
        RKIR_OFF_MASK:
        begin
          s_d.rdata = {5'h00, s_q.mask};
        end
        RKIR_OFF_STATE:
        begin
          s_d.rdata = {4'h0, kickstart_in_n_i, main_supply_ok_i, s_q.pwr_on,
                       (s_q.fill == RKIR_FILL)};
        end
        default:
        begin
          s_d.rdata = RKIR_BYTE_RST;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s_q.abe <= 1'b0;
      s_q.kickstart_enable <= 1'b0;
      s_q.rce <= 1'b0;
      s_q.status <= RKIR_EV_RST;
      s_q.mask <= RKIR_EV_RST;
      s_q.ks_prev <= 1'b1;
      s_q.rc_prev <= 1'b1;
      s_q.pwr_on <= 1'b0;
      s_q.fill <= RKIR_IDLE;
      s_q.addr <= RKIR_BYTE_RST;
      s_q.rdata <= RKIR_BYTE_RST;
      s_q.irq <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Open drain: value always low, enable when asserted
  assign irq_n_o = 1'b0;
  assign irq_oe_o = s_q.irq;
  assign pwr_on_o = s_q.pwr_on;
  assign rdata_o = s_q.rdata;
  assign ram_we_o = (s_q.fill == RKIR_FILL);
  assign ram_addr_o = s_q.addr;
  assign ram_data_o = RKIR_RAM_FILL;

endmodule // rkir_top

/* verification/rkir_assertions.sv */
// Purpose: Port assertions for rkir_top
// Assumes: One clock, sync reset
// Notes: Bind follows the module
`timescale 1ns/10ps
module rkir_chk (
  input wire logic mclk_i, rst_n_i, wr_i, main_supply_ok_i,
  input wire logic kickstart_in_n_i, ram_clear_in_n_i,
  input wire logic irq_n_o, irq_oe_o, pwr_on_o, ram_we_o,
  input wire logic [7:0] ram_addr_o, ram_data_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  pin_low_a: assert property (!irq_n_o) else $error("irq high");
  ks_pwr_a: assert property ($rose(pwr_on_o) |-> !$past(main_supply_ok_i)
    && !$past(kickstart_in_n_i) && $past(kickstart_in_n_i, 2)) else $error("pwr");
  irq_hold_a: assert property (irq_oe_o && !wr_i |=> irq_oe_o) else $error("drop");
  irq_rel_a: assert property ($fell(irq_oe_o) |-> $past(wr_i)) else $error("rel");
  fill_go_a: assert property ($rose(ram_we_o) |-> !ram_addr_o
    && !$past(ram_clear_in_n_i) && $past(ram_clear_in_n_i, 2)) else $error("go");
  fill_step_a: assert property (ram_we_o && $past(ram_we_o)
    |-> ram_addr_o == $past(ram_addr_o) + 8'h01) else $error("step");
  fill_end_a: assert property ($fell(ram_we_o) |-> $past(ram_addr_o) == 8'hf1)
    else $error("end");
  fill_ones_a: assert property (ram_we_o |-> ram_data_o == 8'hff) else $error("ones");
  cover property ($rose(pwr_on_o));
  cover property ($fell(irq_oe_o));
  cover property ($fell(ram_we_o));
endmodule // rkir_chk
bind rkir_top rkir_chk u_chk (.*);

/* verification/rkir_host_mdl.sv */
// Purpose: Host irq input and key switches
// Assumes: Pins pulled up when released
// Notes: A key stays closed three cycles
`timescale 1ns/10ps
module rkir_host_mdl (
  input wire logic mclk_i,
  input wire logic irq_n_o,
  input wire logic irq_oe_o,
  output logic irq_line_o,
  output logic ks_n_o = 1'b1,
  output logic rc_n_o = 1'b1
);
  assign irq_line_o = irq_oe_o ? irq_n_o : 1'b1;
  task automatic press(input bit rc);
    @(posedge mclk_i);
    if (rc) rc_n_o <= 1'b0;
    else ks_n_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rc_n_o <= 1'b1;
    ks_n_o <= 1'b1;
    @(posedge mclk_i);
  endtask
endmodule // rkir_host_mdl

/* verification/rkir_top_tb_top.sv */
// Purpose: Self-checking bench for rkir_top
// Assumes: Host model closes the keys
// Notes: Fill length counted from ram_we_o
`timescale 1ns/10ps
module rkir_top_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sup = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdata, ra, rdat;
  logic irq_n, oe, pwr, we, irq, ks_n, rc_n;
  int failures = 0, num_checks = 0, fills = 0;
  initial forever #2.5 clk = ~clk;
  rkir_top dut (.mclk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .main_supply_ok_i(sup), .kickstart_in_n_i(ks_n),
    .ram_clear_in_n_i(rc_n), .irq_n_o(irq_n), .irq_oe_o(oe), .pwr_on_o(pwr),
    .ram_we_o(we), .ram_addr_o(ra), .ram_data_o(rdat));
  rkir_host_mdl host (.mclk_i(clk), .irq_n_o(irq_n), .irq_oe_o(oe), .irq_line_o(irq),
    .ks_n_o(ks_n), .rc_n_o(rc_n));
  always @(posedge clk)
  begin
    if (we === 1'b1)
    begin
      fills <= fills + 1;
      chk(ra, 8'(fills % 242));
      chk(rdat, 8'hff);
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(4'h0, 8'h00);
    rd_reg(4'h1, 8'h00);
    wr_reg(4'h9, 8'hff);
    rd_reg(4'h9, 8'h00);
    wr_reg(4'h2, 8'h05);
    wr_reg(4'h0, 8'h04);
    host.press(1'b0);
    chk({7'h00, irq}, 8'h00);
    host.press(1'b1);
    repeat (250) @(posedge clk);
    chk(fills[7:0], 8'hf2);
    rd_reg(4'h1, 8'h05);
    wr_reg(4'h1, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr_reg(4'h1, 8'h04);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk);
    sup <= 1'b0;
    host.press(1'b0);
    chk({7'h00, pwr}, 8'h00);
    rd_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h07);
    host.press(1'b0);
    chk({7'h00, pwr}, 8'h01);
    host.press(1'b1);
    repeat (250) @(posedge clk);
    chk(8'(fills - 242), 8'hf2);
    rd_reg(4'h1, 8'h06);
    rd_reg(4'h3, 8'h0a);
    wr_reg(4'h0, 8'h0f);
    chk({7'h00, pwr}, 8'h00);
    wrap_up;
  end
  initial
  begin
    #20000;
    failures++;
    wrap_up;
  end
endmodule // rkir_top_tb_top
